// ===== bench/host_model.sv
// host controller model driving the command and address pins
`timescale 1ns/10ps
module host_model (
  input  wire logic   clk_sys,
  output logic        cs_n,
  output logic        act_n,
  output logic [2:0]  cmd_pins,
  output logic [1:0]  bg,
  output logic [1:0]  ba,
  output logic [13:0] addr,
  output logic        parity
);
  // idle: rank deselected, bus holds a neutral pattern
  initial begin
    cs_n = 1'b1;
    {act_n, cmd_pins, bg, ba, addr} = 22'h2AAAAA;
    parity = 1'b0;
  end

  // one command cycle, launched on the falling edge so setup is half a period
  task automatic send(input logic [21:0] v, input logic sel_n, input logic bad);
    @(negedge clk_sys);
    {act_n, cmd_pins, bg, ba, addr} = v;
    parity = (^v) ^ bad;
    cs_n = sel_n;
    @(negedge clk_sys);
    cs_n = 1'b1;
    // released bus inverted so a stale value can never pass as the next one
    {act_n, cmd_pins, bg, ba, addr} = ~v;
    parity = ~parity;
  endtask : send
endmodule : host_model

// ===== bench/tb.sv
// self-checking bench for the module control-input logic
`timescale 1ns/10ps
module tb;
  import cmd_ctl_pkg::*;
  typedef struct packed {logic perr; cmd_t code; logic [3:0] bank; logic [16:0] row;} note_t;
  logic crc_en, wbv, wbl, wov, woc;
  logic [7:0] wdat, crc_x;
  logic [23:0] e24;
  logic clk_sys, reset_n, cke, odt, rst_pin_n, nv_armed, par_en, rtt_dis, tsf;
  logic vmon, vmon_all, crc_err, cs_n, act_n, parity, cmd_valid, parity_error, alert_n;
  logic clocks_run, drivers_en, cmd_buf_en, ctl_buf_en, termination_strobe_function_c, dram_reset_n, slow;
  logic [2:0] cmd_pins, sas, codes [5];
  logic [1:0] bg, ba, cmd_bg, cmd_ba, dqs_en, dm_en;
  logic [13:0] addr;
  logic [16:0] row_addr;
  logic [3:0] dq_en, lanes, wbd, wod;
  logic [6:0] spd_a, ts_a;
  logic [21:0] v;
  pwr_state_t pwr_state;
  cmd_t cmd_code;
  note_t notes [$];
  note_t n;
  int num_errors = 0, checks = 0, cycles = 0;

  host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .act_n(act_n), .cmd_pins(cmd_pins),
    .bg(bg), .ba(ba), .addr(addr), .parity(parity));
  module_ctl_inputs #(.DQ_WIDTH(4)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .cke(cke),
    .cs_n(cs_n), .act_n(act_n), .ras_n_a16(cmd_pins[2]), .cas_n_a15(cmd_pins[1]),
    .we_n_a14(cmd_pins[0]), .bg(bg), .ba(ba), .addr(addr), .parity(parity), .odt(odt),
    .dram_rst_pin_n(rst_pin_n), .nv_armed(nv_armed), .serial_address_select(sas),
    .parity_enable(par_en), .rtt_disable(rtt_dis), .termination_strobe_function(tsf),
    .crc_enable(crc_en), .vref_monitor_bit(vmon), .vref_monitor_all(vmon_all),
    .wr_crc_error(crc_err), .wr_beat_valid(wbv), .wr_beat_last(wbl), .wr_beat_data(wbd),
    .clocks_run(clocks_run), .drivers_en(drivers_en), .cmd_buf_en(cmd_buf_en),
    .ctl_buf_en(ctl_buf_en), .pwr_state(pwr_state), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .row_addr(row_addr), .cmd_bg(cmd_bg), .cmd_ba(cmd_ba),
    .parity_error(parity_error), .alert_n(alert_n), .term_dq_en(dq_en),
    .term_dqs_en(dqs_en), .term_dm_en(dm_en), .term_termination_strobe_function_c_en(termination_strobe_function_c),
    .dram_reset_n(dram_reset_n), .vref_mon_lanes(lanes), .training_slow(slow),
    .spd_i2c_addr(spd_a), .ts_i2c_addr(ts_a), .wr_out_valid(wov), .wr_out_is_crc(woc),
    .wr_out_data(wod));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string nm, input logic [24:0] e, input logic [24:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic finish_test;
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // expected decode of one bus value {act_n, ras, cas, we, bg, ba, addr}
  function automatic note_t expect_of(input logic [21:0] w, input logic perr);
    note_t e;
    e = '{perr, CMD_NONE, 4'h0, 17'h00000};
    if (!perr) begin
      e.bank = w[17:14];
      e.row = w[21] ? {3'h0, w[13:0]} : {w[20:18], w[13:0]};
      case (w[20:18])
        CODE_MRS: e.code = CMD_MRS;
        CODE_REF: e.code = CMD_REF;
        CODE_PRE: e.code = CMD_PRE;
        CODE_WR:  e.code = CMD_WR;
        CODE_RD:  e.code = CMD_RD;
        default:  e.code = CMD_OTHER;
      endcase
      if (!w[21]) e.code = CMD_ACT;
    end
    return e;
  endfunction : expect_of

  task automatic send_exp(input logic [21:0] w, input logic bad, input logic perr);
    notes.push_back(expect_of(w, perr));
    host.send(w, 1'b0, bad);
  endtask : send_exp

  // results come out one cycle wide; the oldest note is matched against each one
  always @(negedge clk_sys) begin
    if (cmd_valid === 1'b1 || parity_error === 1'b1) begin
      if (notes.size() == 0) check("unexpected result", 21'h0, 21'h1FFFFF);
      else begin
        n = notes.pop_front();
        check("command", n, parity_error ? {1'b1, CMD_NONE, 21'h0} :
              {1'b0, cmd_code, cmd_bg, cmd_ba, row_addr});
      end
    end
  end

  // hang guard, far above the under two hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    {reset_n, cke, odt, rst_pin_n, nv_armed, par_en, rtt_dis, tsf} = 8'h5C;
    {vmon, vmon_all, crc_err, crc_en, wbv, wbl, wbd} = 10'h000;
    codes = '{CODE_RD, CODE_WR, CODE_PRE, CODE_MRS, CODE_REF};
    v = 22'($urandom(34));
    sas = 3'($urandom);
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    send_exp({1'b0, 21'($urandom)}, 1'b0, 1'b0);
    // five command codes, NOP left out; A10 high so the precharge closes all banks
    for (int i = 0; i < 5; i++) begin
      v = {1'b1, codes[i], 18'($urandom)};
      v[10] = 1'b1;
      send_exp(v, 1'b0, 1'b0);
    end
    host.send(22'($urandom), 1'b1, 1'b0);
    send_exp({1'b1, CODE_RD, 18'($urandom)}, 1'b1, 1'b1);
    repeat (4) @(negedge clk_sys);
    check("alert after parity", 21'h0, alert_n);
    repeat (30) @(negedge clk_sys);
    par_en = 1'b0;
    send_exp({1'b1, CODE_WR, 18'($urandom)}, 1'b1, 1'b0);
    repeat (4) @(negedge clk_sys);
    crc_err = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("alert after crc", 21'h0, alert_n);
    repeat (10) @(negedge clk_sys);
    // refresh as cke falls gives self refresh, idle banks precharge power-down,
    // an open row active power-down
    for (int i = 0; i < 3; i++) begin
      if (i == 2) send_exp({1'b0, 21'($urandom)}, 1'b0, 1'b0);
      repeat (4) @(negedge clk_sys);
      fork
        if (i == 0) send_exp({1'b1, CODE_REF, 18'($urandom)}, 1'b0, 1'b0);
        begin
          if (i == 0) @(negedge clk_sys);
          cke = 1'b0;
        end
      join
      repeat (6) @(negedge clk_sys);
      check("power state", i == 0 ? PWR_SELF_REF : (i == 1 ? PWR_PRE_PD : PWR_ACT_PD),
            pwr_state);
      check("gating", {3'b000, i != 0},
            {clocks_run, drivers_en, cmd_buf_en, ctl_buf_en});
      cke = 1'b1;
      if (i == 0) #1 check("raw cke wake", 21'h1, clocks_run);
      repeat (6) @(negedge clk_sys);
      check("awake", {PWR_ACTIVE, 1'b1}, {pwr_state, clocks_run});
    end
    odt = 1'b1;
    for (int i = 0; i < 2; i++) begin
      tsf = i[0];
      repeat (5) @(negedge clk_sys);
      check("termination", {4'hF, 2'h1, 1'b0, tsf, tsf}, {dq_en, dqs_en, dm_en, termination_strobe_function_c});
    end
    rtt_dis = 1'b1;
    repeat (5) @(negedge clk_sys);
    check("termination off", 21'h0, {dq_en, dqs_en, dm_en, termination_strobe_function_c});
    vmon = 1'b1;
    for (int i = 0; i < 2; i++) begin
      vmon_all = i[0];
      repeat (4) @(negedge clk_sys);
      check("vref lanes", {1'b1, i ? 4'hF : 4'h1}, {slow, lanes});
    end
    check("i2c", {SPD_I2C_BASE, sas, TS_I2C_BASE, sas}, {spd_a, ts_a});
    // two-beat write burst, crc tail on then off; crc-8 msb first from zero
    wdat = 8'($urandom);
    crc_x = CRC_RESET;
    for (int k = 7; k >= 0; k--) begin
      crc_x = {crc_x[6:0], 1'b0} ^ ((crc_x[7] ^ wdat[k]) ? CRC_POLY : 8'h00);
    end
    for (int j = 0; j < 2; j++) begin
      crc_en = !j[0];
      e24 = {2'b10, wdat[7:4], 2'b10, wdat[3:0], 2'b11, crc_x[7:4], 2'b11, crc_x[3:0]};
      for (int k = 0; k < 4; k++) begin
        {wbv, wbl, wbd} = k < 2 ? {1'b1, k[0], wdat[7-4*k -: 4]} : 6'h00;
        @(negedge clk_sys);
        check("write beat", (j && k > 1) ? {2'b00, wod} : e24[23-6*k -: 6],
              {wov, woc, wod});
      end
    end
    {rst_pin_n, nv_armed} = 2'h1;
    #1 check("reset blocked", 21'h1, dram_reset_n);
    @(negedge clk_sys);
    nv_armed = 1'b0;
    #1 check("reset passed", 21'h0, dram_reset_n);
    @(negedge clk_sys);
    rst_pin_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("notes left", 21'h0, notes.size());
    finish_test();
  end
endmodule : tb

// ===== verilog/ca_parity_check.sv
// even parity check over the command/address bundle
`timescale 1ns/10ps
module ca_parity_check #(
  parameter int unsigned N = 24
) (
  input  wire logic [N-1:0] covered,
  input  wire logic         parity_bit,
  output logic              mismatch
);
  import cmd_ctl_pkg::*;

  // odd total of ones over bundle plus parity bit is an error
  assign mismatch = ^{covered, parity_bit};
endmodule : ca_parity_check

// ===== verilog/cmd_ctl_pkg.sv
// constants and types shared by the module control-input logic
// Overview of operation
// - clock enable high runs clocks, receivers, drivers
// - low enters precharge/self-refresh or active power-down
// - self-refresh exit seen from clock enable asynchronously
// - power-down keeps only clock, ODT, reset, CKE; clocks_run is off there
// - self refresh keeps only clock enable, reset
// - chip select high ignores the command
// - ODT terminates data, strobes, mask on x4/x8; mask only with termination_strobe_function
// - x16 terminates all data, both strobes, masks
// - termination disabled means ODT input ignored
// - parity covers command, bank and address bits
// - activate low makes command pins row bits
// - reset asynchronous while low, held high normally
// - armed nonvolatile backup blocks the reset input
// - CRC appended after last data beat
// - VREF monitor bit routes reference onto DQ0-3; code drives DQ0 only unless vref_monitor_all
// - data width is 4, 8 or 16
// - serial address select sets I2C address range
// - inputs sampled on rising clock edge
// - parity error holds alert, CRC error pulses
package cmd_ctl_pkg;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned PAR_RECOVER_NS   = 100;
  localparam int unsigned CRC_ALERT_NS     = 24;
  localparam int unsigned PAR_RECOVER_CYC  = (PAR_RECOVER_NS * CLK_MHZ) / 1000;
  localparam int unsigned CRC_ALERT_CYC    = (CRC_ALERT_NS * CLK_MHZ) / 1000;
  localparam int unsigned ALERT_CNT_W      = 8;
  localparam int unsigned DQ_WIDTH_DEF     = 4;
  localparam int unsigned CRC_W            = 8;
  localparam logic [7:0]  CRC_POLY         = 8'h07;
  localparam logic [7:0]  CRC_RESET        = 8'h00;
  localparam logic [3:0]  SPD_I2C_BASE     = 4'hA;
  localparam logic [3:0]  TS_I2C_BASE      = 4'h3;
  localparam int unsigned BANK_COUNT       = 16;
  localparam int unsigned ADDR_LOW_BIT_A10 = 10;
  // pin synchroniser value in reset: deselected, cke, act, command pins and reset pin high, rest low
  localparam logic [31:0] PIN_IDLE         = 32'hFC00_0020;
  // command pin codes {ras, cas, we} with activate high
  localparam logic [2:0]  CODE_MRS         = 3'h0;
  localparam logic [2:0]  CODE_REF         = 3'h1;
  localparam logic [2:0]  CODE_PRE         = 3'h2;
  localparam logic [2:0]  CODE_WR          = 3'h4;
  localparam logic [2:0]  CODE_RD          = 3'h5;
  localparam logic [2:0]  CODE_NOP         = 3'h7;

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF} pwr_state_t;
  typedef enum logic [2:0] {CMD_NONE, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS,
                            CMD_OTHER} cmd_t;
endpackage : cmd_ctl_pkg

// ===== verilog/crc_burst_append.sv
// write burst pass-through that appends a CRC after the last beat
`timescale 1ns/10ps
module crc_burst_append #(
  parameter int unsigned DQ_WIDTH = cmd_ctl_pkg::DQ_WIDTH_DEF
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                crc_enable,
  input  wire logic                beat_valid,
  input  wire logic                beat_last,
  input  wire logic [DQ_WIDTH-1:0] beat_data,
  output logic                     out_valid,
  output logic                     out_is_crc,
  output logic [DQ_WIDTH-1:0]      out_data
);
  import cmd_ctl_pkg::*;

  localparam int unsigned CRC_BEATS = (CRC_W + DQ_WIDTH - 1) / DQ_WIDTH;
  localparam int unsigned PAD_W     = CRC_BEATS * DQ_WIDTH;

  logic [CRC_W-1:0]    crc_q, crc_d;
  logic [PAD_W-1:0]    shift_q, shift_d;
  logic [3:0]          left_q, left_d;
  logic                valid_q, valid_d, iscrc_q, iscrc_d;
  logic [DQ_WIDTH-1:0] data_q, data_d;

  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                input logic [DQ_WIDTH-1:0] d);
    logic [CRC_W-1:0] r;
    r = c;
    for (int i = DQ_WIDTH - 1; i >= 0; i--) begin
      r = (r[CRC_W-1] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  // data beats pass through; crc beats follow the last one, msb first
  always_comb begin
    crc_d   = crc_q;
    shift_d = shift_q;
    left_d  = left_q;
    valid_d = 1'b0;
    iscrc_d = 1'b0;
    data_d  = data_q;
    if (left_q != 4'h0) begin
      valid_d = 1'b1;
      iscrc_d = 1'b1;
      data_d  = shift_q[PAD_W-1 -: DQ_WIDTH];
      shift_d = shift_q << DQ_WIDTH;
      left_d  = left_q - 4'h1;
    end else if (beat_valid) begin
      valid_d = 1'b1;
      data_d  = beat_data;
      crc_d   = crc_step(crc_q, beat_data);
      if (beat_last) begin
        crc_d = CRC_RESET;
        if (crc_enable) begin
          shift_d = PAD_W'({crc_step(crc_q, beat_data), {(PAD_W - CRC_W){1'b0}}});
          left_d  = 4'(CRC_BEATS);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crc_q   <= CRC_RESET;
      shift_q <= '0;
      left_q  <= 4'h0;
      valid_q <= 1'b0;
      iscrc_q <= 1'b0;
      data_q  <= '0;
    end else begin
      crc_q   <= crc_d;
      shift_q <= shift_d;
      left_q  <= left_d;
      valid_q <= valid_d;
      iscrc_q <= iscrc_d;
      data_q  <= data_d;
    end
  end

  assign out_valid  = valid_q;
  assign out_is_crc = iscrc_q;
  assign out_data   = data_q;

  property p_crc_after_last;
    @(posedge clk_sys) disable iff (!rst_n)
      (beat_valid && beat_last && crc_enable && left_q == 4'h0) |=> ##1 (out_is_crc && out_valid);
  endproperty
  a_crc_after_last: assert property (p_crc_after_last) else $error("crc beat missing");

  property p_no_crc_disabled;
    @(posedge clk_sys) disable iff (!rst_n)
      (beat_valid && beat_last && !crc_enable && left_q == 4'h0) |=> ##1 !out_is_crc;
  endproperty
  a_no_crc_disabled: assert property (p_no_crc_disabled) else $error("crc beat when off");
endmodule : crc_burst_append

// ===== verilog/module_ctl_inputs.sv
// command, control and power-state input logic of the memory module
`timescale 1ns/10ps
module module_ctl_inputs #(
  parameter int unsigned DQ_WIDTH = cmd_ctl_pkg::DQ_WIDTH_DEF
) (
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  input  wire logic                cke,
  input  wire logic                cs_n,
  input  wire logic                act_n,
  input  wire logic                ras_n_a16,
  input  wire logic                cas_n_a15,
  input  wire logic                we_n_a14,
  input  wire logic [1:0]          bg,
  input  wire logic [1:0]          ba,
  input  wire logic [13:0]         addr,
  input  wire logic                parity,
  input  wire logic                odt,
  input  wire logic                dram_rst_pin_n,
  input  wire logic                nv_armed,
  input  wire logic [2:0]          serial_address_select,
  input  wire logic                parity_enable,
  input  wire logic                rtt_disable,
  input  wire logic                termination_strobe_function,
  input  wire logic                crc_enable,
  input  wire logic                vref_monitor_bit,
  input  wire logic                vref_monitor_all,
  input  wire logic                wr_crc_error,
  input  wire logic                wr_beat_valid,
  input  wire logic                wr_beat_last,
  input  wire logic [DQ_WIDTH-1:0] wr_beat_data,
  output logic                     clocks_run,
  output logic                     drivers_en,
  output logic                     cmd_buf_en,
  output logic                     ctl_buf_en,
  output cmd_ctl_pkg::pwr_state_t  pwr_state,
  output logic                     cmd_valid,
  output cmd_ctl_pkg::cmd_t        cmd_code,
  output logic [16:0]              row_addr,
  output logic [1:0]               cmd_bg,
  output logic [1:0]               cmd_ba,
  output logic                     parity_error,
  output logic                     alert_n,
  output logic [DQ_WIDTH-1:0]      term_dq_en,
  output logic [1:0]               term_dqs_en,
  output logic [1:0]               term_dm_en,
  output logic                     term_termination_strobe_function_c_en,
  output logic                     dram_reset_n,
  output logic [3:0]               vref_mon_lanes,
  output logic                     training_slow,
  output logic [6:0]               spd_i2c_addr,
  output logic [6:0]               ts_i2c_addr,
  output logic                     wr_out_valid,
  output logic                     wr_out_is_crc,
  output logic [DQ_WIDTH-1:0]      wr_out_data
);
  import cmd_ctl_pkg::*;

  localparam int unsigned NSYNC = 32;

  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // pins in pin_raw cross two flops; dram reset pins and cke are also read raw
  logic [NSYNC-1:0] pin_raw, meta_q, pin_q;
  assign pin_raw = {cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr,
                    parity, odt, dram_rst_pin_n, nv_armed, serial_address_select,
                    wr_crc_error};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= PIN_IDLE;
      pin_q  <= PIN_IDLE;
    end else begin
      meta_q <= pin_raw;
      pin_q  <= meta_q;
    end
  end

  logic        s_cke, s_cs_n, s_act_n, s_ras, s_cas, s_we, s_par, s_odt, s_rst_n, s_armed;
  logic        s_crc_err;
  logic [1:0]  s_bg, s_ba;
  logic [13:0] s_addr;
  logic [2:0]  s_sa;
  assign {s_cke, s_cs_n, s_act_n, s_ras, s_cas, s_we, s_bg, s_ba, s_addr, s_par, s_odt,
          s_rst_n, s_armed, s_sa, s_crc_err} = pin_q;

  // dram reset acts without the clock; an armed backup masks the pin
  assign dram_reset_n = dram_rst_pin_n | nv_armed;
  logic dev_rst;
  assign dev_rst = !s_rst_n && !s_armed;

  // decode of the sampled command
  logic [2:0] pins_code;
  pwr_state_t pwr_q, pwr_d;
  cmd_t       dec_cmd;
  logic       cmd_live;
  assign pins_code = {s_ras, s_cas, s_we};
  assign cmd_live  = !s_cs_n && (pwr_q == PWR_ACTIVE);
  always_comb begin
    dec_cmd = CMD_OTHER;
    if (!s_act_n) begin
      dec_cmd = CMD_ACT;
    end else begin
      unique case (pins_code)
        CODE_MRS: dec_cmd = CMD_MRS;
        CODE_REF: dec_cmd = CMD_REF;
        CODE_PRE: dec_cmd = CMD_PRE;
        CODE_WR:  dec_cmd = CMD_WR;
        CODE_RD:  dec_cmd = CMD_RD;
        CODE_NOP: dec_cmd = CMD_NONE;
        default:  dec_cmd = CMD_OTHER;
      endcase
    end
  end

  // parity over act, muxed pins, bank group, bank and address
  logic par_mismatch, par_err;
  ca_parity_check #(.N(22)) u_par (
    .covered    ({s_act_n, s_ras, s_cas, s_we, s_bg, s_ba, s_addr}),
    .parity_bit (s_par),
    .mismatch   (par_mismatch)
  );
  // parity only means anything on a selected cycle
  assign par_err = cmd_live && parity_enable && par_mismatch;

  // open-row tracking and power state
  logic [BANK_COUNT-1:0]  open_q, open_d;
  logic                   prev_cke_q, prev_cke_d;
  logic [3:0]             bank_idx;
  assign bank_idx = {s_bg, s_ba};
  always_comb begin
    pwr_d      = pwr_q;
    open_d     = open_q;
    prev_cke_d = s_cke;
    if (dev_rst) begin
      pwr_d  = PWR_ACTIVE;
      open_d = '0;
    end else begin
      if (cmd_live && !par_err) begin
        if (dec_cmd == CMD_ACT) begin
          open_d[bank_idx] = 1'b1;
        end else if (dec_cmd == CMD_PRE) begin
          if (s_addr[ADDR_LOW_BIT_A10]) begin
            open_d = '0;
          end else begin
            open_d[bank_idx] = 1'b0;
          end
        end
      end
      unique case (pwr_q)
        PWR_ACTIVE: begin
          // no burst check on entry: host never drops cke mid-access
          if (prev_cke_q && !s_cke) begin
            if (open_q != '0) begin
              pwr_d = PWR_ACT_PD;
            end else if (cmd_live && dec_cmd == CMD_REF) begin
              pwr_d = PWR_SELF_REF;
            end else begin
              pwr_d = PWR_PRE_PD;
            end
          end
        end
        PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF: begin
          if (s_cke) begin
            pwr_d = PWR_ACTIVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q      <= PWR_ACTIVE;
      open_q     <= '0;
      prev_cke_q <= 1'b1;
    end else begin
      pwr_q      <= pwr_d;
      open_q     <= open_d;
      prev_cke_q <= prev_cke_d;
    end
  end
  assign pwr_state = pwr_q;

  // raw cke wakes the clocks straight away in self refresh, no sampling
  assign clocks_run = (pwr_q == PWR_ACTIVE) || ((pwr_q == PWR_SELF_REF) && cke);
  assign drivers_en = (pwr_q == PWR_ACTIVE);
  assign cmd_buf_en = (pwr_q == PWR_ACTIVE);
  assign ctl_buf_en = (pwr_q != PWR_SELF_REF);

  // registered command outputs
  logic        valid_q, valid_d, perr_q, perr_d;
  cmd_t        cmd_q, cmd_d;
  logic [16:0] row_q, row_d;
  logic [1:0]  bg_q, bg_d, ba_q, ba_d;
  always_comb begin
    valid_d = cmd_live && !par_err && !dev_rst && dec_cmd != CMD_NONE;
    cmd_d   = valid_d ? dec_cmd : CMD_NONE;
    row_d   = s_act_n ? {3'h0, s_addr} : {s_ras, s_cas, s_we, s_addr};
    bg_d    = s_bg;
    ba_d    = s_ba;
    perr_d  = par_err;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      cmd_q   <= CMD_NONE;
      row_q   <= '0;
      bg_q    <= 2'h0;
      ba_q    <= 2'h0;
      perr_q  <= 1'b0;
    end else begin
      valid_q <= valid_d;
      cmd_q   <= cmd_d;
      row_q   <= row_d;
      bg_q    <= bg_d;
      ba_q    <= ba_d;
      perr_q  <= perr_d;
    end
  end
  assign cmd_valid    = valid_q;
  assign cmd_code     = cmd_q;
  assign row_addr     = row_q;
  assign cmd_bg       = bg_q;
  assign cmd_ba       = ba_q;
  assign parity_error = perr_q;

  // alert: long hold for parity recovery, short pulse for crc; parity wins
  logic [ALERT_CNT_W-1:0] alert_cnt_q, alert_cnt_d;
  logic                   alert_q, alert_d, crc_err_prev_q;
  always_comb begin
    alert_cnt_d = alert_cnt_q;
    if (par_err) begin
      alert_cnt_d = ALERT_CNT_W'(PAR_RECOVER_CYC);
    end else if (s_crc_err && !crc_err_prev_q && alert_cnt_q == '0) begin
      alert_cnt_d = ALERT_CNT_W'(CRC_ALERT_CYC);
    end else if (alert_cnt_q != '0) begin
      alert_cnt_d = alert_cnt_q - 1'b1;
    end
    alert_d = (alert_cnt_d == '0);
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alert_cnt_q    <= '0;
      alert_q        <= 1'b1;
      crc_err_prev_q <= 1'b0;
    end else begin
      alert_cnt_q    <= alert_cnt_d;
      alert_q        <= alert_d;
      crc_err_prev_q <= s_crc_err;
    end
  end
  assign alert_n = alert_q;

  // termination, vref lanes and i2c address registered; training_slow follows vref_monitor_bit directly
  logic                odt_on;
  logic [DQ_WIDTH-1:0] tdq_q, tdq_d;
  logic [1:0]          termination_strobe_function_q, termination_strobe_function_d, tdm_q, tdm_d;
  logic                tdqsc_q, tdqsc_d;
  logic [3:0]          vmon_q, vmon_d;
  logic [6:0]          spd_q, spd_d, ts_q, ts_d;
  // odt buffer is dead in self refresh, so it cannot terminate there
  assign odt_on = s_odt && !rtt_disable && ctl_buf_en;
  always_comb begin
    tdq_d   = {DQ_WIDTH{odt_on}};
    if (DQ_WIDTH == 16) begin
      termination_strobe_function_d  = {2{odt_on}};
      tdm_d   = {2{odt_on}};
      tdqsc_d = 1'b0;
    end else begin
      termination_strobe_function_d  = {1'b0, odt_on};
      tdm_d   = {1'b0, odt_on && termination_strobe_function};
      tdqsc_d = odt_on && termination_strobe_function;
    end
    vmon_d = !vref_monitor_bit ? 4'h0 : (vref_monitor_all ? 4'hF : 4'h1);
    spd_d  = {SPD_I2C_BASE, s_sa};
    ts_d   = {TS_I2C_BASE, s_sa};
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tdq_q   <= '0;
      termination_strobe_function_q  <= 2'h0;
      tdm_q   <= 2'h0;
      tdqsc_q <= 1'b0;
      vmon_q  <= 4'h0;
      spd_q   <= 7'h00;
      ts_q    <= 7'h00;
    end else begin
      tdq_q   <= tdq_d;
      termination_strobe_function_q  <= termination_strobe_function_d;
      tdm_q   <= tdm_d;
      tdqsc_q <= tdqsc_d;
      vmon_q  <= vmon_d;
      spd_q   <= spd_d;
      ts_q    <= ts_d;
    end
  end
  assign term_dq_en     = tdq_q;
  assign term_dqs_en    = termination_strobe_function_q;
  assign term_dm_en     = tdm_q;
  assign term_termination_strobe_function_c_en = tdqsc_q;
  assign vref_mon_lanes = vmon_q;
  assign training_slow  = vref_monitor_bit;
  assign spd_i2c_addr   = spd_q;
  assign ts_i2c_addr    = ts_q;

  // write burst path with crc tail
  crc_burst_append #(.DQ_WIDTH(DQ_WIDTH)) u_crc (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .crc_enable (crc_enable),
    .beat_valid (wr_beat_valid),
    .beat_last  (wr_beat_last),
    .beat_data  (wr_beat_data),
    .out_valid  (wr_out_valid),
    .out_is_crc (wr_out_is_crc),
    .out_data   (wr_out_data)
  );

  property p_cs_high_ignored;
    @(posedge clk_sys) disable iff (!rst_n) s_cs_n |=> !cmd_valid;
  endproperty
  a_cs_high_ignored: assert property (p_cs_high_ignored) else $error("deselected cmd taken");

  property p_pd_open_rows;
    @(posedge clk_sys) disable iff (!rst_n)
      (pwr_q == PWR_ACTIVE && prev_cke_q && !s_cke && open_q != '0 && !dev_rst)
      |=> pwr_q == PWR_ACT_PD;
  endproperty
  a_pd_open_rows: assert property (p_pd_open_rows) else $error("no active power-down");

  property p_pd_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      (pwr_q == PWR_ACTIVE && prev_cke_q && !s_cke && open_q == '0 && !dev_rst)
      |=> (pwr_q == PWR_PRE_PD || pwr_q == PWR_SELF_REF);
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("idle entry wrong");

  property p_sr_buffers;
    @(posedge clk_sys) disable iff (!rst_n) pwr_q == PWR_SELF_REF |-> !ctl_buf_en && !cmd_buf_en;
  endproperty
  a_sr_buffers: assert property (p_sr_buffers) else $error("buffers on in self refresh");

  property p_pd_buffers;
    @(posedge clk_sys) disable iff (!rst_n)
      (pwr_q == PWR_PRE_PD || pwr_q == PWR_ACT_PD) |-> ctl_buf_en && !cmd_buf_en && !drivers_en;
  endproperty
  a_pd_buffers: assert property (p_pd_buffers) else $error("power-down buffers wrong");

  property p_rtt_off;
    @(posedge clk_sys) disable iff (!rst_n) rtt_disable |=> term_dq_en == '0;
  endproperty
  a_rtt_off: assert property (p_rtt_off) else $error("odt not ignored");

  property p_parity_flag;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmd_live && parity_enable && (^{s_act_n, s_ras, s_cas, s_we, s_bg, s_ba, s_addr, s_par}))
      |=> parity_error && !cmd_valid ##1 !alert_n;
  endproperty
  a_parity_flag: assert property (p_parity_flag) else $error("parity error missed");

  property p_act_row;
    @(posedge clk_sys) disable iff (!rst_n)
      (cmd_live && !s_act_n && !par_err && !dev_rst)
      |=> cmd_valid && cmd_code == CMD_ACT && row_addr[16:14] == $past({s_ras, s_cas, s_we});
  endproperty
  a_act_row: assert property (p_act_row) else $error("row bits wrong");

  property p_armed_blocks;
    @(posedge clk_sys) disable iff (!rst_n) nv_armed |-> dram_reset_n;
  endproperty
  a_armed_blocks: assert property (p_armed_blocks) else $error("reset not blocked");
endmodule : module_ctl_inputs
